// *** bench/epf_meter_chk.sv ***
// ********
// Port checker
// ********
module epf_meter_chk #(
    parameter int unsigned POWERUP_TICKS  = 20,
    parameter int unsigned CF_PULSE_TICKS = 2
) (
    input wire logic                 i_clk_sys,
    input wire logic                 i_rst_b,
    input wire epf_pkg::epf_chan_t   i_phase_current_input,
    input wire epf_pkg::epf_chan_t   i_neutral_current_input,
    input wire epf_pkg::epf_wb_req_t i_wb,
    input wire logic                 o_wb_ack,
    input wire logic [31:0]          o_wb_dat,
    input wire logic                 o_low_rate_pulse_a,
    input wire logic                 o_low_rate_pulse_b,
    input wire logic                 o_calibration_pulse_out,
    input wire logic                 o_fault
);
    timeunit 1ns;
    timeprecision 100ps;
    // Ticks are 444 or 445 clocks apart, so widths get slack.
    localparam int CF_MIN = 444 * CF_PULSE_TICKS - 1;
    localparam int CF_MAX = 445 * CF_PULSE_TICKS + 1;
    localparam int UP_MIN = 444 * (POWERUP_TICKS - 1) - 4;
    logic [31:0] cf_len;
    logic [31:0] since_chg;
    logic [31:0] since_rst;
    logic [3:0]  light_len;
    logic        light;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    assign light = (i_phase_current_input.mag < 16'h00c4) && (i_neutral_current_input.mag < 16'h00c4);
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cf_len    <= 32'h0;
            since_chg <= 32'h0;
            since_rst <= 32'h0;
            light_len <= 4'h0;
        end else begin
            cf_len    <= o_calibration_pulse_out ? cf_len + 32'h1 : 32'h0;
            since_chg <= $changed(o_fault) ? 32'h1 : since_chg + 32'h1;
            since_rst <= since_rst + 32'h1;
            light_len <= !light ? 4'h0 : ((light_len == 4'hf) ? light_len : light_len + 4'h1);
        end
    end
    AST_PULSE_PAIR: assert property (o_low_rate_pulse_a == o_low_rate_pulse_b)
        else $error("low-rate outputs differ");
    AST_CF_WIDTH: assert property ($fell(o_calibration_pulse_out) |-> cf_len >= CF_MIN && cf_len <= CF_MAX)
        else $error("calibration pulse width off");
    AST_FAULT_POWERUP: assert property (since_rst < UP_MIN |-> !o_fault)
        else $error("alarm before power-up decision");
    AST_FAULT_FILTER: assert property ($changed(o_fault) |-> since_chg >= UP_MIN)
        else $error("alarm changed without filtering");
    AST_LIGHT_HOLD: assert property (light_len == 4'hf |-> $stable(o_fault))
        else $error("alarm moved at light load");
    AST_RESET_QUIET: assert property ($rose(i_rst_b) |-> !o_fault && !o_calibration_pulse_out)
        else $error("outputs active after reset");
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    AST_ACK_TIMING: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack late");
    AST_ACK_CAUSE: assert property ($rose(o_wb_ack) |-> $past(i_wb.cyc && i_wb.stb))
        else $error("ack without request");
    AST_DAT_HOLD: assert property ($changed(o_wb_dat) |-> o_wb_ack)
        else $error("read data moved without ack");
    cover property ($rose(o_calibration_pulse_out));
    cover property ($rose(o_fault));
    cover property ($fell(o_fault));
endmodule : epf_meter_chk

// *** bench/epf_pulse_counter.sv ***
// ********
// Far-side pulse counter
// ********
module epf_pulse_counter (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        i_pulse,
    output logic      [31:0] o_count
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev;
    // A counter input only registers the rising edge of an active-high pulse.
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev    <= 1'b0;
            o_count <= 32'h0;
        end else begin
            prev <= i_pulse;
            if (i_pulse && !prev) begin
                o_count <= o_count + 32'h1;
            end
        end
    end
endmodule : epf_pulse_counter

// *** bench/tb.sv ***
// ********
// Bench
// ********
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 clk;
    logic                 rst_b;
    logic                 s_lsb;
    logic                 s_msb;
    logic                 s_scf;
    epf_pkg::epf_chan_t   ph;
    epf_pkg::epf_chan_t   ne;
    epf_pkg::epf_wb_req_t wb;
    logic                 ack;
    logic [31:0]          rdat;
    logic                 low_a;
    logic                 low_b;
    logic                 cf;
    logic                 fault;
    logic [31:0]          cf_cnt;
    int                   num_errors;
    int                   checks_done;

    epf_meter_core #(
        .POWERUP_TICKS  (20),
        .FAULT_TICKS    (40),
        .LOW_PULSE_TICKS(5),
        .CF_PULSE_TICKS (2)
    ) i_epf_meter_core (
        .i_clk_sys              (clk),
        .i_rst_b                (rst_b),
        .i_rate_select_lsb      (s_lsb),
        .i_rate_select_msb      (s_msb),
        .i_calib_scale_select   (s_scf),
        .i_phase_current_input  (ph),
        .i_neutral_current_input(ne),
        .i_wb                   (wb),
        .o_wb_ack               (ack),
        .o_wb_dat               (rdat),
        .o_low_rate_pulse_a     (low_a),
        .o_low_rate_pulse_b     (low_b),
        .o_calibration_pulse_out(cf),
        .o_fault                (fault)
    );

    epf_pulse_counter i_epf_pulse_counter (
        .i_clk_sys(clk),
        .i_rst_b  (rst_b),
        .i_pulse  (cf),
        .o_count  (cf_cnt)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk);
        wb.cyc <= 1'b1;
        wb.stb <= 1'b1;
        wb.we  <= we;
        wb.sel <= 4'hf;
        wb.adr <= adr;
        wb.dat <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        wb.cyc <= 1'b0;
        wb.stb <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            end_of_test();
        end
    endtask : wb_xfer

    task automatic wait_ticks(input int n);
        repeat (n * 4000 / 9) @(posedge clk);
    endtask : wait_ticks

    task automatic wait_fault(input logic v, input int ticks);
        int n;
        n = 0;
        while (fault !== v && n < ticks * 445) begin
            @(posedge clk);
            n++;
        end
        if (fault !== v) begin
            num_errors++;
            end_of_test();
        end
    endtask : wait_fault

    task automatic t_reset();
        logic [31:0] rv;
        wb_xfer(1'b1, 4'h6, 32'h0, rv);
        wb_xfer(1'b0, epf_pkg::ADR_CTRL, 32'h0, rv);
        chk(rv, 32'h1);
        wb_xfer(1'b0, 4'h2, 32'h0, rv);
        chk(rv, 32'h0);
        wb_xfer(1'b0, epf_pkg::ADR_STATUS, 32'h0, rv);
        chk(32'(rv[7:5]), 32'h3);
        chk(32'(rv[4:0]), 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_powerup();
        logic [31:0] rv;
        wait_ticks(10);
        chk(32'(fault), 32'h0);
        chk(cf_cnt, 32'h0);
        wait_fault(1'b1, 15);
        wb_xfer(1'b0, epf_pkg::ADR_STATUS, 32'h0, rv);
        chk(32'(rv[4:0]), 32'h13);
        $display("test power-up done");
    endtask : t_powerup

    task automatic t_calib();
        logic [31:0] rv;
        logic [31:0] base;
        logic [31:0] d;
        logic [63:0] lo;
        wb_xfer(1'b1, epf_pkg::ADR_CTRL, 32'h3, rv);
        base = cf_cnt;
        wait_ticks(60);
        // Ratio 2048 is a right shift by 11.
        lo = 64'd60 * 64'h7fff / (64'(epf_pkg::LOW_THR_FAST) >> 11);
        d = cf_cnt - base;
        chk(32'(d == lo[31:0] || d == lo[31:0] + 32'h1), 32'h1);
        wb_xfer(1'b0, epf_pkg::ADR_CAL_COUNT, 32'h0, rv);
        chk(rv, cf_cnt - base);
        wb_xfer(1'b0, epf_pkg::ADR_LOW_COUNT, 32'h0, rv);
        chk(rv, 32'h0);
        ne.power <= 16'h8001;
        repeat (4) @(posedge clk);
        base = cf_cnt;
        wait_ticks(30);
        chk(cf_cnt - base, 32'h0);
        $display("test calibration done");
    endtask : t_calib

    task automatic t_clear();
        logic [31:0] rv;
        ph.mag <= 16'h2000;
        wait_ticks(20);
        chk(32'(fault), 32'h1);
        wait_fault(1'b0, 30);
        wb_xfer(1'b0, epf_pkg::ADR_STATUS, 32'h0, rv);
        chk(32'(rv[1:0]), 32'h2);
        ph.mag <= 16'h0010;
        ne.mag <= 16'h0080;
        wait_ticks(45);
        chk(32'(fault), 32'h0);
        $display("test clear and light load done");
    endtask : t_clear

    initial begin
        rst_b       = 1'b0;
        s_lsb       = 1'b1;
        s_msb       = 1'b1;
        s_scf       = 1'b0;
        ph          = {16'h0000, 16'h1000};
        ne          = {16'h7fff, 16'h2000};
        wb          = '0;
        num_errors  = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_powerup();
        t_calib();
        t_clear();
        end_of_test();
    end
endmodule : tb

bind epf_meter_core epf_meter_chk #(
    .POWERUP_TICKS (POWERUP_TICKS),
    .CF_PULSE_TICKS(CF_PULSE_TICKS)
) i_epf_meter_chk (.*);

// *** hdl/epf_meter_core.sv ***
// ************************************************************************
// Energy pulse rate generator with channel fault selection
// ************************************************************************
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
module epf_meter_core #(
    parameter int unsigned POWERUP_TICKS   = epf_pkg::POWERUP_TICKS,
    parameter int unsigned FAULT_TICKS     = epf_pkg::FAULT_TICKS,
    parameter int unsigned LOW_PULSE_TICKS = epf_pkg::LOW_PULSE_TICKS,
    parameter int unsigned CF_PULSE_TICKS  = epf_pkg::CF_PULSE_TICKS
) (
    // Clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_b,
    // Select pins, asynchronous
    input  wire logic                 i_rate_select_lsb,
    input  wire logic                 i_rate_select_msb,
    input  wire logic                 i_calib_scale_select,
    // Filtered channel data, same clock
    input  wire epf_pkg::epf_chan_t   i_phase_current_input,
    input  wire epf_pkg::epf_chan_t   i_neutral_current_input,
    // Wishbone slave
    input  wire epf_pkg::epf_wb_req_t i_wb,
    output logic                      o_wb_ack,
    output logic [31:0]               o_wb_dat,
    // Pulse and alarm outputs
    output logic                      o_low_rate_pulse_a,
    output logic                      o_low_rate_pulse_b,
    output logic                      o_calibration_pulse_out,
    output logic                      o_fault
);
    localparam int PW = epf_pkg::PWR_W;
    localparam int AW = epf_pkg::ACC_W;
    localparam int CW = epf_pkg::CNT_W;

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        logic [2:0]    sel_meta;
        logic [2:0]    sel_sync;
        logic [AW-1:0] low_acc;
        logic [AW-1:0] cal_acc;
        logic          low_fire;
        logic          cal_fire;
        logic          neutral_active;
        logic          alarm;
        logic          settled;
        logic [CW-1:0] persist;
        logic          ack;
        logic [31:0]   rdata;
        logic          enable;
        logic [31:0]   low_count;
        logic [31:0]   cal_count;
    } epf_core_state_t;

    epf_core_state_t st;
    epf_core_state_t next_st;
    logic            tick;

    // ********************************************************************
    // Channel comparison helpers
    // ********************************************************************
    // True when a exceeds b by more than a sixteenth of a.
    function automatic logic exceeds(input logic [PW-1:0] a, input logic [PW-1:0] b);
        logic [PW-1:0] diff;
        diff = a - b;
        return (a > b) && (diff > (a >> epf_pkg::DIFF_SHIFT));
    endfunction : exceeds

    // True when a has fallen below fifteen sixteenths of b.
    function automatic logic below(input logic [PW-1:0] a, input logic [PW-1:0] b);
        return a < (b - (b >> epf_pkg::DIFF_SHIFT));
    endfunction : below

    // ********************************************************************
    // Timebase and output stages
    // ********************************************************************
    epf_tick_gen #(
        .CLK_HZ  (epf_pkg::CLK_HZ),
        .TICK_HZ (epf_pkg::TIMEBASE_HZ)
    ) u_tick (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .o_tick    (tick)
    );

    epf_pulse_stretch #(
        .WIDTH_TICKS (LOW_PULSE_TICKS)
    ) u_low_a (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_tick    (tick),
        .i_fire    (st.low_fire),
        .o_pulse   (o_low_rate_pulse_a)
    );

    epf_pulse_stretch #(
        .WIDTH_TICKS (LOW_PULSE_TICKS)
    ) u_low_b (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_tick    (tick),
        .i_fire    (st.low_fire),
        .o_pulse   (o_low_rate_pulse_b)
    );

    epf_pulse_stretch #(
        .WIDTH_TICKS (CF_PULSE_TICKS)
    ) u_cal (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_tick    (tick),
        .i_fire    (st.cal_fire),
        .o_pulse   (o_calibration_pulse_out)
    );

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    always_comb begin
        logic [1:0]    rate_code;
        logic          scale_hi;
        logic [3:0]    ratio_log2;
        logic [AW-1:0] low_thr;
        logic [AW-1:0] cal_thr;
        logic [PW-1:0] bill_power;
        logic [AW-1:0] low_sum;
        logic [AW-1:0] cal_sum;
        logic [PW-1:0] mag_p;
        logic [PW-1:0] mag_n;
        logic          inhibit;
        logic          swap_want;
        logic          alarm_want;
        logic          pending;
        logic          hit;
        logic [CW-1:0] delay;
        logic          wb_req;

        next_st    = st;
        rate_code  = {st.sel_sync[1], st.sel_sync[0]};
        scale_hi   = st.sel_sync[2];
        ratio_log2 = '0;
        low_thr    = '0;
        cal_thr    = '0;
        bill_power = '0;
        low_sum    = '0;
        cal_sum    = '0;
        mag_p      = i_phase_current_input.mag;
        mag_n      = i_neutral_current_input.mag;
        inhibit    = 1'b0;
        swap_want  = 1'b0;
        alarm_want = 1'b0;
        pending    = 1'b0;
        hit        = 1'b0;
        delay      = '0;
        wb_req     = 1'b0;

        // Pins are only read after the second stage.
        next_st.sel_meta = {i_calib_scale_select, i_rate_select_msb, i_rate_select_lsb}; // RQ21
        next_st.sel_sync = st.sel_meta; // RQ21

        // Slower base rates divide the timebase by a larger power of two, so
        // the threshold grows by one bit per step down.
        low_thr = epf_pkg::LOW_THR_FAST << (epf_pkg::RATE_CODE_FAST - rate_code); // RQ3 RQ4 RQ2 RQ9 RQ10
        if (scale_hi) begin
            ratio_log2 = epf_pkg::RATIO_LOG2_HI[rate_code]; // RQ6
        end else begin
            ratio_log2 = epf_pkg::RATIO_LOG2_LO[rate_code]; // RQ7
        end
        cal_thr = low_thr >> ratio_log2; // RQ5 RQ8

        // Billing power comes from the active channel; reverse power adds nothing.
        if (st.neutral_active) begin // RQ12
            bill_power = i_neutral_current_input.power[PW-1] ? '0 : i_neutral_current_input.power;
        end else begin
            bill_power = i_phase_current_input.power[PW-1] ? '0 : i_phase_current_input.power;
        end

        // Digital-to-frequency conversion.
        next_st.low_fire = 1'b0;
        next_st.cal_fire = 1'b0;
        if (tick) begin
            low_sum = st.low_acc + AW'(bill_power); // RQ20
            cal_sum = st.cal_acc + AW'(bill_power); // RQ8
            if (low_sum >= low_thr) begin
                next_st.low_acc  = low_sum - low_thr; // RQ20
                next_st.low_fire = st.enable; // RQ1
            end else begin
                next_st.low_acc = low_sum;
            end
            if (cal_sum >= cal_thr) begin
                next_st.cal_acc  = cal_sum - cal_thr; // RQ20
                next_st.cal_fire = st.enable; // RQ5
            end else begin
                next_st.cal_acc = cal_sum;
            end
        end

        // Fault detection and channel selection, independent of pulse output.
        inhibit = (mag_p < epf_pkg::LIGHT_LOAD_MAG) && (mag_n < epf_pkg::LIGHT_LOAD_MAG); // RQ15
        if (st.neutral_active) begin
            swap_want  = exceeds(mag_p, mag_n); // RQ18
            alarm_want = below(mag_p, mag_n) || swap_want; // RQ18
        end else begin
            swap_want  = exceeds(mag_n, mag_p); // RQ17 RQ14
            alarm_want = below(mag_n, mag_p) || swap_want; // RQ16 RQ11
        end
        pending = !inhibit && (swap_want || (alarm_want != st.alarm)); // RQ19
        delay   = st.settled ? CW'(FAULT_TICKS) : CW'(POWERUP_TICKS); // RQ14 RQ16

        if (tick) begin
            if (!st.settled) begin
                hit = (st.persist + CW'(1)) >= delay;
                next_st.persist = hit ? '0 : st.persist + CW'(1);
                if (hit) begin
                    next_st.settled = 1'b1;
                    if (!inhibit) begin
                        next_st.alarm = alarm_want; // RQ14
                        next_st.neutral_active = st.neutral_active ^ swap_want; // RQ14 RQ13
                    end
                end
            end else if (pending) begin
                hit = (st.persist + CW'(1)) >= delay;
                next_st.persist = hit ? '0 : st.persist + CW'(1);
                if (hit) begin
                    next_st.alarm = alarm_want; // RQ11 RQ16 RQ17 RQ18
                    next_st.neutral_active = st.neutral_active ^ swap_want; // RQ12 RQ17 RQ18
                end
            end else begin
                next_st.persist = '0;
            end
        end

        // Wishbone classic slave: one wait state, ack for one cycle.
        wb_req     = i_wb.cyc && i_wb.stb && !st.ack;
        next_st.ack = wb_req;
        if (wb_req && i_wb.we && i_wb.sel[0] && i_wb.adr == epf_pkg::ADR_CTRL) begin
            next_st.enable = i_wb.dat[epf_pkg::CTRL_EN_BIT];
        end
        if (wb_req && !i_wb.we) begin
            case (i_wb.adr)
                epf_pkg::ADR_CTRL: begin
                    next_st.rdata = {31'h0, st.enable};
                end
                epf_pkg::ADR_STATUS: begin
                    next_st.rdata = {24'h0, st.sel_sync, st.settled, 2'h0, st.neutral_active, st.alarm};
                end
                epf_pkg::ADR_LOW_COUNT: begin
                    next_st.rdata = st.low_count;
                end
                epf_pkg::ADR_CAL_COUNT: begin
                    next_st.rdata = st.cal_count;
                end
                default: begin
                    next_st.rdata = 32'h0;
                end
            endcase
        end

        // Pulse counters; a count event in the clearing cycle is kept.
        if (wb_req && i_wb.we && i_wb.sel[0] && i_wb.adr == epf_pkg::ADR_CTRL
            && i_wb.dat[epf_pkg::CTRL_CLR_BIT]) begin
            next_st.low_count = {31'h0, st.low_fire};
            next_st.cal_count = {31'h0, st.cal_fire};
        end else begin
            next_st.low_count = st.low_count + {31'h0, st.low_fire};
            next_st.cal_count = st.cal_count + {31'h0, st.cal_fire};
        end
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st        <= '0;
            st.enable <= epf_pkg::CTRL_EN_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_wb_ack = st.ack;
    assign o_wb_dat = st.rdata;
    assign o_fault  = st.alarm;
endmodule : epf_meter_core

// *** hdl/epf_pkg.sv ***
// Contract
// RQ1 - Filtered active power becomes active-high pulse trains on both low-rate outputs.
// RQ2 - Low-rate rate is 5.70 times Vrms product times base rate over Vref squared.
// RQ3 - Rate select codes 00..11 give base rates oscillator over 2^18..2^15.
// RQ4 - Base rates are binary divisions of the timebase and scale with it.
// RQ5 - Calibration output is an integer multiple, at most 2048, of low rate.
// RQ6 - Scale select high gives ratios 128, 64, 32, 16 for codes 00..11.
// RQ7 - Scale select low gives ratios 64, 32, 16 and 2048 for codes 00..11.
// RQ8 - Calibration output uses same power accumulated over a proportionally shorter period.
// RQ9 - Full-scale ac gives half the pulse rate of full-scale dc.
// RQ10 - Ac maxima: 0.34 to 2.72 Hz low rate, 43.52, 21.76 or 5570 Hz calibration.
// RQ11 - Fault is signalled when phase and neutral magnitudes differ over 6.25 percent.
// RQ12 - Billing always uses the larger current channel, even during a fault. Code bills the active channel, swapped after a filtered excess.
// RQ13 - After power-up billing uses the phase channel until a swap occurs.
// RQ14 - Power-up mismatch raises the alarm after about one second; larger neutral takes billing.
// RQ15 - Fault detection is inhibited below 0.3 percent of full scale.
// RQ16 - Neutral below 93.75 percent of active phase alarms after three seconds, no swap.
// RQ17 - Neutral above phase by over 6.25 percent alarms and swaps after three seconds.
// RQ18 - Swap back needs phase over neutral by 6.25 percent; alarm clears when within.
// RQ19 - The alarm output is independent of pulse activity on the low-rate outputs.
// RQ20 - Each conversion accumulates power, pulses and subtracts a threshold on crossing.
// RQ21 - Rate and scale select pins are synchronised before choosing dividers and ratios.
package epf_pkg;

    // ********************************************************************
    // Widths and timing
    // ********************************************************************
    localparam int          PWR_W            = 16;
    localparam int          ACC_W            = 40;
    localparam int          CNT_W            = 24;
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned TIMEBASE_HZ      = 450_000;
    localparam int unsigned POWERUP_DELAY_MS = 1000;
    localparam int unsigned FAULT_DELAY_MS   = 3000;
    localparam int unsigned LOW_PULSE_MS     = 100;
    localparam int unsigned CF_PULSE_US      = 90;
    localparam int unsigned POWERUP_TICKS    = TIMEBASE_HZ / 1000 * POWERUP_DELAY_MS;
    localparam int unsigned FAULT_TICKS      = TIMEBASE_HZ / 1000 * FAULT_DELAY_MS;
    localparam int unsigned LOW_PULSE_TICKS  = TIMEBASE_HZ / 1000 * LOW_PULSE_MS;
    localparam int unsigned CF_PULSE_TICKS   = TIMEBASE_HZ / 1000 * CF_PULSE_US / 1000;

    // ********************************************************************
    // Conversion constants
    // ********************************************************************
    // Threshold at the fastest base rate: full-scale dc power gives 5.44 Hz.
    localparam logic [ACC_W-1:0] LOW_THR_FAST   = 40'h00a1904b4b;
    localparam logic [1:0]       RATE_CODE_FAST = 2'h3;
    localparam logic [PWR_W-1:0] LIGHT_LOAD_MAG = 16'h00c4;
    localparam int               DIFF_SHIFT     = 4;

    // Log2 of the calibration ratio, indexed by rate code.
    localparam logic [3:0] RATIO_LOG2_HI [4] = '{4'h7, 4'h6, 4'h5, 4'h4};
    localparam logic [3:0] RATIO_LOG2_LO [4] = '{4'h6, 4'h5, 4'h4, 4'hb};

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [3:0]  ADR_CTRL      = 4'h0;
    localparam logic [3:0]  ADR_STATUS    = 4'h4;
    localparam logic [3:0]  ADR_LOW_COUNT = 4'h8;
    localparam logic [3:0]  ADR_CAL_COUNT = 4'hc;
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          CTRL_CLR_BIT  = 1;
    localparam logic        CTRL_EN_RESET = 1'b1;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } epf_wb_req_t;

    typedef struct packed {
        logic signed [PWR_W-1:0] power;
        logic        [PWR_W-1:0] mag;
    } epf_chan_t;

endpackage : epf_pkg

// *** hdl/epf_pulse_stretch.sv ***
// ************************************************************************
// Fixed-width active-high output pulse, timed in timebase ticks
// ************************************************************************
module epf_pulse_stretch #(
    parameter int unsigned WIDTH_TICKS = epf_pkg::CF_PULSE_TICKS
) (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    // Control
    input  wire logic i_tick,
    input  wire logic i_fire,
    // Pulse
    output logic      o_pulse
);
    // A fire that arrives while the pulse stands is merged into it; at the
    // documented maximum rates the pulse is always shorter than the period.
    typedef struct packed {
        logic [epf_pkg::CNT_W-1:0] remain;
        logic                      level;
    } epf_stretch_state_t;

    epf_stretch_state_t st;
    epf_stretch_state_t next_st;

    always_comb begin
        next_st = st;
        if (i_fire && !st.level) begin
            next_st.level  = 1'b1;
            next_st.remain = epf_pkg::CNT_W'(WIDTH_TICKS);
        end else if (st.level && i_tick) begin
            if (st.remain <= epf_pkg::CNT_W'(1)) begin
                next_st.level  = 1'b0;
                next_st.remain = '0;
            end else begin
                next_st.remain = st.remain - epf_pkg::CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_pulse = st.level;
endmodule : epf_pulse_stretch

// *** hdl/epf_tick_gen.sv ***
// ************************************************************************
// Master timebase tick from the system clock
// ************************************************************************
module epf_tick_gen #(
    parameter int unsigned CLK_HZ  = epf_pkg::CLK_HZ,
    parameter int unsigned TICK_HZ = epf_pkg::TIMEBASE_HZ
) (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    // Tick
    output logic      o_tick
);
    // A fractional accumulator keeps the long-run tick rate exact even though
    // the clock is not an integer multiple of the timebase.
    typedef struct packed {
        logic [31:0] phase;
        logic        tick;
    } epf_tick_state_t;

    epf_tick_state_t st;
    epf_tick_state_t next_st;
    logic [32:0]     sum;

    always_comb begin
        next_st = st;
        sum = {1'b0, st.phase} + 33'(TICK_HZ);
        if (sum >= 33'(CLK_HZ)) begin
            next_st.phase = 32'(sum - 33'(CLK_HZ));
            next_st.tick  = 1'b1;
        end else begin
            next_st.phase = sum[31:0];
            next_st.tick  = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
endmodule : epf_tick_gen
